// [hdl/tmr_event_counters.sv]
// three 16-bit counters, two timer/event and one timer-only, with byte-buffered cpu access
`timescale 1ns/10ps
`default_nettype none
module tmr_event_counters (
  // clock and reset
  input  wire logic                          clk_sys,
  input  wire logic                          rst,
  // cpu special register access
  input  wire logic [3:0]                    cpu_addr,
  input  wire logic                          cpu_wr,
  input  wire logic                          cpu_rd,
  input  wire logic [7:0]                    cpu_wdata,
  output logic [7:0]                         cpu_rdata,
  // external timer pins
  input  wire logic                          ctr0_ext_input,
  input  wire logic                          ctr1_ext_input,
  // interrupt controller and power manager
  input  wire logic [tmr_pkg::NUM_CTR-1:0]   ctr_irq_en,
  input  wire logic                          power_down,
  output logic [tmr_pkg::NUM_CTR-1:0]        ctr_ovf_req,
  output logic [tmr_pkg::NUM_CTR-1:0]        ctr_irq,
  output logic                               wake_req
);
  import tmr_pkg::*;

  // synchronised pin views, indexed by counter
  logic [NUM_EXT-1:0] pin_raw;
  logic [NUM_EXT-1:0] pin_level;
  logic [NUM_EXT-1:0] pin_rise;
  logic [NUM_EXT-1:0] pin_fall;

  // rate dividers
  logic [1:0]         div4_reg;
  logic [1:0]         div4_next;
  logic               div4_tick;
  logic [23:0]        acc_reg;
  logic [23:0]        acc_next;
  logic [24:0]        acc_sum;
  logic               slow_tick;

  // per-counter decode and state
  logic [NUM_CTR-1:0] wr_low;
  logic [NUM_CTR-1:0] wr_high;
  logic [NUM_CTR-1:0] wr_ctrl;
  logic [NUM_CTR-1:0] rd_low;
  logic [NUM_CTR-1:0] rd_high;
  logic [NUM_CTR-1:0] rd_ctrl;
  logic [NUM_CTR-1:0] int_tick;
  logic [NUM_CTR-1:0] run;
  logic [NUM_CTR-1:0] edge_fall;
  logic [NUM_CTR-1:0] inc;
  logic [NUM_CTR-1:0] ovf;
  logic [NUM_CTR-1:0] hw_stop;
  mode_t              mode     [NUM_CTR];
  logic [7:0]         ctrl_reg [NUM_CTR];
  logic [7:0]         ctrl_next[NUM_CTR];
  logic [7:0]         lowbuf_reg [NUM_CTR];
  logic [7:0]         lowbuf_next[NUM_CTR];
  logic [15:0]        count    [NUM_CTR];
  logic [7:0]         rd_byte  [NUM_CTR];

  // output holding registers
  logic [7:0]         rdata_reg;
  logic [7:0]         rdata_next;
  logic [NUM_CTR-1:0] ovf_req_reg;
  logic [NUM_CTR-1:0] irq_reg;
  logic               wake_reg;

  // pins cross from outside, two flops before any use
  assign pin_raw = {ctr1_ext_input, ctr0_ext_input};

  genvar p;
  generate
    for (p = 0; p < NUM_EXT; p++) begin : g_pin
      pin_edge_sync u_sync (
        .clk_sys   (clk_sys),
        .rst       (rst),
        .pin_async (pin_raw[p]),
        .pin_level (pin_level[p]),
        .pin_rise  (pin_rise[p]),
        .pin_fall  (pin_fall[p])
      );
    end
  endgenerate

  // system clock / 4 enable for the first counter
  assign div4_next = div4_reg + 2'h1;
  assign div4_tick = (div4_reg == DIV4_LAST);

  // 32768 hz enable by phase accumulation; average rate is
  // exact, single ticks jitter by one system clock
  assign acc_sum   = {1'b0, acc_reg} + ACC_STEP;
  assign slow_tick = (acc_sum >= ACC_MOD);
  assign acc_next  = slow_tick ? 24'(acc_sum - ACC_MOD) : acc_sum[23:0];

  // divider state
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      div4_reg <= 2'h0;
      acc_reg  <= 24'h000000;
    end else begin
      div4_reg <= div4_next;
      acc_reg  <= acc_next;
    end
  end

  // internal clocks stop while powered down, pin edges do not
  assign int_tick[0] = div4_tick & ~power_down;
  assign int_tick[1] = slow_tick & ~power_down;
  assign int_tick[2] = ~power_down;

  genvar i;
  generate
    for (i = 0; i < NUM_CTR; i++) begin : g_ctr

      // address decode for this counter's three bytes
      assign wr_low[i]  = cpu_wr & addr_hit(cpu_addr, i, OFS_LOW);
      assign wr_high[i] = cpu_wr & addr_hit(cpu_addr, i, OFS_HIGH);
      assign wr_ctrl[i] = cpu_wr & addr_hit(cpu_addr, i, OFS_CTRL);
      assign rd_low[i]  = cpu_rd & addr_hit(cpu_addr, i, OFS_LOW);
      assign rd_high[i] = cpu_rd & addr_hit(cpu_addr, i, OFS_HIGH);
      assign rd_ctrl[i] = cpu_rd & addr_hit(cpu_addr, i, OFS_CTRL);

      // control field views
      assign mode[i]      = mode_t'(ctrl_reg[i][MODE_HI:MODE_LO]);
      assign run[i]       = ctrl_reg[i][RUN_BIT];
      assign edge_fall[i] = ctrl_reg[i][EDGE_BIT];

      if (i < NUM_EXT) begin : g_ext
        pw_state_t pw_reg;
        pw_state_t pw_next;
        logic      pw_start;
        logic      pw_end;
        logic      pw_armed;
        logic      ev_edge;

        // active edge; pulse mode starts on the opposite sense
        // to event mode: bit 3 clear starts on a falling edge
        assign ev_edge  = edge_fall[i] ? pin_fall[i] : pin_rise[i];
        assign pw_armed = run[i] && (mode[i] == MODE_PULSE);
        assign pw_start = pw_armed && (pw_reg == PW_WAIT) &&
                          (edge_fall[i] ? pin_rise[i] : pin_fall[i]);
        assign pw_end   = (pw_reg == PW_MEAS) &&
                          (edge_fall[i] ? pin_fall[i] : pin_rise[i]);

        // measuring ends when disarmed or the pin returns to idle
        assign pw_next = pw_start ? PW_MEAS :
                         (!pw_armed || pw_end) ? PW_WAIT : pw_reg;

        always_ff @(posedge clk_sys or posedge rst) begin
          if (rst) begin
            pw_reg <= PW_WAIT;
          end else begin
            pw_reg <= pw_next;
          end
        end

        // run bit falls by itself at the end of a pulse
        assign hw_stop[i] = pw_armed && pw_end;

        // advance source per mode; stopped pattern never counts
        assign inc[i] =
          (mode[i] == MODE_TIMER) ? (run[i] & int_tick[i]) :
          (mode[i] == MODE_EVENT) ? (run[i] & ev_edge) :
          (mode[i] == MODE_PULSE) ? (run[i] & int_tick[i] &
                                     (pw_reg == PW_MEAS)) :
          1'b0;

        // pin level is not needed beyond the edge pulses
        logic unused_level;
        assign unused_level = pin_level[i];
      end else begin : g_int
        // timer mode only, every other pattern holds still
        assign inc[i]     = run[i] & int_tick[i] &
                            (mode[i] == MODE_TIMER);
        assign hw_stop[i] = 1'b0;
      end

      // control write: software write wins over the self-clear
      assign ctrl_next[i] =
        wr_ctrl[i] ? (cpu_wdata & ((i < NUM_EXT) ? CTRL_MASK
                                                 : CTRL2_MASK)) :
        hw_stop[i] ? (ctrl_reg[i] & ~(8'h01 << RUN_BIT)) :
        ctrl_reg[i];

      // low byte buffer: writes park here, high reads latch here
      assign lowbuf_next[i] =
        wr_low[i]  ? cpu_wdata :
        rd_high[i] ? count[i][7:0] :
        lowbuf_reg[i];

      always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
          ctrl_reg[i]   <= CTRL_RESET;
          lowbuf_reg[i] <= BYTE_RESET;
        end else begin
          ctrl_reg[i]   <= ctrl_next[i];
          lowbuf_reg[i] <= lowbuf_next[i];
        end
      end

      // high write moves buffered low in with it, one 16-bit
      // preload; a live load happens only while stopped
      count_unit u_count (
        .clk_sys     (clk_sys),
        .rst         (rst),
        .inc         (inc[i]),
        .preload_wr  (wr_high[i]),
        .load_now    (~run[i]),
        .preload_val ({cpu_wdata, lowbuf_reg[i]}),
        .count       (count[i]),
        .ovf         (ovf[i])
      );

      // read byte for this counter; low returns the latch
      assign rd_byte[i] =
        rd_low[i]  ? lowbuf_reg[i] :
        rd_high[i] ? count[i][15:8] :
        rd_ctrl[i] ? ctrl_reg[i] :
        BYTE_RESET;
    end
  endgenerate

  // unmapped addresses read as zero; only one counter hits
  assign rdata_next = cpu_rd ? (rd_byte[0] | rd_byte[1] | rd_byte[2])
                             : rdata_reg;

  // registered read data and overflow outputs
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rdata_reg   <= BYTE_RESET;
      ovf_req_reg <= '0;
      irq_reg     <= '0;
      wake_reg    <= 1'b0;
    end else begin
      rdata_reg   <= rdata_next;
      ovf_req_reg <= ovf;
      irq_reg     <= ovf & ctr_irq_en;
      wake_reg    <= (|ovf) & power_down;
    end
  end

  // wake ignores the enables, as a sleeping part must still rise
  assign cpu_rdata   = rdata_reg;
  assign ctr_ovf_req = ovf_req_reg;
  assign ctr_irq     = irq_reg;
  assign wake_req    = wake_reg;

endmodule // tmr_event_counters
`default_nettype wire

// [hdl/tmr_pkg.sv]
// shared constants, types and decode helpers for the timer/event counters
package tmr_pkg;

  // counter population
  localparam int unsigned NUM_CTR     = 3;
  localparam int unsigned NUM_EXT     = 2;

  // register locations: three bytes per counter, stride of four
  localparam logic [3:0] CTR_STRIDE   = 4'h4;
  localparam logic [3:0] OFS_LOW      = 4'h0;
  localparam logic [3:0] OFS_HIGH     = 4'h1;
  localparam logic [3:0] OFS_CTRL     = 4'h2;

  // control register fields
  localparam int unsigned MODE_HI     = 7;
  localparam int unsigned MODE_LO     = 6;
  localparam int unsigned RUN_BIT     = 4;
  localparam int unsigned EDGE_BIT    = 3;
  localparam logic [7:0] CTRL_MASK    = 8'hd8;
  localparam logic [7:0] CTRL2_MASK   = 8'hd0;
  localparam logic [7:0] CTRL_RESET   = 8'h00;

  // counter values
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [15:0] COUNT_FULL  = 16'hffff;
  localparam logic [7:0]  BYTE_RESET  = 8'h00;

  // clock rates
  localparam int unsigned SYS_CLK_PERIOD_NS = 100;
  localparam int unsigned SYS_CLK_HZ  = 1_000_000_000 / SYS_CLK_PERIOD_NS;
  localparam int unsigned SLOW_HZ     = 32768;
  localparam int unsigned DIV4_RATIO  = 4;
  localparam logic [1:0]  DIV4_LAST   = 2'(DIV4_RATIO - 1);
  localparam logic [24:0] ACC_MOD     = 25'(SYS_CLK_HZ);
  localparam logic [24:0] ACC_STEP    = 25'(SLOW_HZ);

  // operating modes from control bits 7:6
  typedef enum logic [1:0] {
    MODE_STOP  = 2'b00,
    MODE_EVENT = 2'b01,
    MODE_TIMER = 2'b10,
    MODE_PULSE = 2'b11
  } mode_t;

  // pulse width measurement progress
  typedef enum logic {
    PW_WAIT = 1'b0,
    PW_MEAS = 1'b1
  } pw_state_t;

  // true when addr names byte ofs of counter idx
  function automatic logic addr_hit(input logic [3:0] addr,
                                    input int unsigned idx,
                                    input logic [3:0] ofs);
    logic [3:0] base;
    base = 4'(idx * 4);
    addr_hit = (addr == (base | ofs));
  endfunction

endpackage

// [hdl/pin_edge_sync.sv]
// two-stage synchroniser with edge pulses for an external timer pin
`timescale 1ns/10ps
`default_nettype none
module pin_edge_sync (
  // clock and reset
  input  wire logic clk_sys,
  input  wire logic rst,
  // raw pin
  input  wire logic pin_async,
  // synchronised level and one-cycle edge pulses
  output logic      pin_level,
  output logic      pin_rise,
  output logic      pin_fall
);

  logic meta_reg;
  logic sync_reg;
  logic hist_reg;

  // only sync_reg reads meta_reg; edges use later stages
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      hist_reg <= 1'b0;
    end else begin
      meta_reg <= pin_async;
      sync_reg <= meta_reg;
      hist_reg <= sync_reg;
    end
  end

  // one pulse per transition, so each edge counts once
  assign pin_level = sync_reg;
  assign pin_rise  = sync_reg & ~hist_reg;
  assign pin_fall  = ~sync_reg & hist_reg;

endmodule // pin_edge_sync
`default_nettype wire

// [hdl/count_unit.sv]
// one 16-bit count-up register with preload and overflow reload
`timescale 1ns/10ps
`default_nettype none
module count_unit
  import tmr_pkg::*;
(
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst,
  // advance request
  input  wire logic        inc,
  // preload write
  input  wire logic        preload_wr,
  input  wire logic        load_now,
  input  wire logic [15:0] preload_val,
  // state
  output logic [15:0]      count,
  output logic             ovf
);

  logic [15:0] count_reg;
  logic [15:0] count_next;
  logic [15:0] preload_reg;
  logic [15:0] preload_next;
  logic        wrap;

  // preload powers up unknown; reset gives it zero anyway
  assign preload_next = preload_wr ? preload_val : preload_reg;
  assign wrap         = inc && (count_reg == COUNT_FULL);
  // zero preload gives the full 65536-step range
  assign count_next   = (preload_wr && load_now) ? preload_val :
                        wrap ? preload_next :
                        inc  ? count_reg + 16'h0001 :
                        count_reg;

  // counter and preload hold
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      count_reg   <= COUNT_RESET;
      preload_reg <= COUNT_RESET;
    end else begin
      count_reg   <= count_next;
      preload_reg <= preload_next;
    end
  end

  assign count = count_reg;
  assign ovf   = wrap;

endmodule // count_unit
`default_nettype wire

// [bench/tmr_event_counters_monitor.sv]
// port-level assertion checker for the timer/event counters
`timescale 1ns/10ps
`default_nettype none
module tmr_event_counters_monitor
  import tmr_pkg::*;
(
  // clock and reset
  input wire logic               clk_sys,
  input wire logic               rst,
  // cpu access
  input wire logic [3:0]         cpu_addr,
  input wire logic               cpu_rd,
  input wire logic [7:0]         cpu_rdata,
  // events
  input wire logic [NUM_CTR-1:0] ctr_irq_en,
  input wire logic               power_down,
  input wire logic [NUM_CTR-1:0] ctr_ovf_req,
  input wire logic [NUM_CTR-1:0] ctr_irq,
  input wire logic               wake_req
);
  // one clock domain, so clocking and disable are shared
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  AST_RST_QUIET: assert property ($past(rst) |->
    ctr_ovf_req == 3'h0 && !wake_req)
    else $error("event output right after reset");
  AST_IRQ_GATE: assert property (
    ctr_irq == (ctr_ovf_req & $past(ctr_irq_en)))
    else $error("irq does not follow overflow and enable");
  AST_WAKE: assert property (
    wake_req == (|ctr_ovf_req && $past(power_down)))
    else $error("wake does not follow overflow in power down");
  // div4 ticks and synchronised pin edges are never back to back
  AST_OVF_PULSE: assert property (ctr_ovf_req[0] |=>
    !ctr_ovf_req[0])
    else $error("overflow pulse longer than one cycle");
  AST_RDATA_HOLD: assert property (!$past(cpu_rd) |->
    $stable(cpu_rdata))
    else $error("read data moved without a read");
  AST_CTRL_RSVD: assert property ($past(cpu_rd) &&
    $past(cpu_addr) inside {4'h2, 4'h6} |-> (cpu_rdata & 8'h27) == 8'h00)
    else $error("reserved control bit reads set");
  AST_CTR2_RSVD: assert property ($past(cpu_rd) &&
    $past(cpu_addr) == 4'ha |-> (cpu_rdata & 8'h2f) == 8'h00)
    else $error("counter 2 control has extra bits");
  AST_UNMAPPED: assert property ($past(cpu_rd) &&
    ($past(cpu_addr[1:0]) == 2'h3 || $past(cpu_addr) > 4'ha)
    |-> cpu_rdata == 8'h00)
    else $error("unmapped index reads nonzero");
endmodule // tmr_event_counters_monitor
`default_nettype wire

// [bench/pin_source.sv]
// external timer pin driver standing for the far side
`timescale 1ns/10ps
`default_nettype none
module pin_source (
  // clock
  input  wire logic clk_sys,
  // pin toward the counter
  output var logic  pin
);
  // level launched just after an edge, then held whole cycles
  initial pin = 1'b0;
  task automatic hold(input logic v, input int cyc);
    @(posedge clk_sys);
    pin <= v;
    repeat (cyc) @(posedge clk_sys);
  endtask
endmodule // pin_source
`default_nettype wire

// [bench/tmr_event_counters_test.sv]
// self-checking bench for the timer/event counters
`timescale 1ns/10ps
`default_nettype none
module tmr_event_counters_test;
  import tmr_pkg::*;
  logic clk_sys, rst, cpu_wr, cpu_rd, power_down;
  logic [3:0] cpu_addr;
  logic [7:0] cpu_wdata;
  logic [7:0] cpu_rdata;
  logic [2:0] ctr_irq_en, ctr_ovf_req, ctr_irq;
  logic wake_req, pin0, pin1;
  int err_count = 0;
  int n_compared = 0;

  tmr_event_counters u_dut (.clk_sys(clk_sys), .rst(rst),
    .cpu_addr(cpu_addr), .cpu_wr(cpu_wr), .cpu_rd(cpu_rd),
    .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata),
    .ctr0_ext_input(pin0), .ctr1_ext_input(pin1),
    .ctr_irq_en(ctr_irq_en), .power_down(power_down),
    .ctr_ovf_req(ctr_ovf_req), .ctr_irq(ctr_irq), .wake_req(wake_req));
  pin_source u_pin0 (.clk_sys(clk_sys), .pin(pin0));
  pin_source u_pin1 (.clk_sys(clk_sys), .pin(pin1));

  // 10 mhz clock
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  task automatic finish_test;
    $display("compared %0d mismatched %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t got %h want %h", $time, got, exp);
    end
  endtask
  // strobes last one taking edge; released on that edge
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    cpu_wr <= 1'b1;
    cpu_addr <= a;
    cpu_wdata <= d;
    @(posedge clk_sys);
    cpu_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    cpu_rd <= 1'b1;
    cpu_addr <= a;
    @(posedge clk_sys);
    cpu_rd <= 1'b0;
    #1 d = cpu_rdata;
  endtask
  // low byte first, so the high write moves a fresh buffer in
  task automatic ld16(input int i, input logic [15:0] v);
    wr(4'(4 * i), v[7:0]);
    wr(4'(4 * i + 1), v[15:8]);
  endtask
  task automatic rd16(input int i, output logic [15:0] v);
    rd(4'(4 * i + 1), v[15:8]);
    rd(4'(4 * i), v[7:0]);
  endtask
  task automatic wait_ovf(input int i, input int lim, output int n);
    n = 0;
    do begin
      @(posedge clk_sys);
      #1 n++;
    end while (ctr_ovf_req[i] !== 1'b1 && n < lim);
    if (n >= lim) chk(16'h0001, 16'h0000);
  endtask

  task automatic t_regs;
    logic [7:0] b;
    logic [15:0] v;
    rd(4'h2, b);
    chk({8'h00, b}, 16'h0000);
    wr(4'h3, 8'hff);
    rd(4'h3, b);
    chk({8'h00, b}, 16'h0000);
    wr(4'h2, 8'hff);
    rd(4'h2, b);
    chk({8'h00, b}, 16'h00d8);
    wr(4'h2, 8'h00);
    wr(4'ha, 8'h5f);
    rd(4'ha, b);
    chk({8'h00, b}, 16'h0050);
    repeat (20) @(posedge clk_sys);
    rd16(2, v);
    chk(v, 16'h0000);
    wr(4'ha, 8'h00);
  endtask
  task automatic t_bytes;
    logic [15:0] v;
    wr(4'h0, 8'h34);
    rd16(0, v);
    chk(v, 16'h0000);
    ld16(0, 16'h1234);
    rd16(0, v);
    chk(v, 16'h1234);
  endtask
  task automatic t_timer0;
    int n;
    ld16(0, 16'hfffe);
    wr(4'h2, 8'h90);
    ctr_irq_en <= 3'h1;
    wait_ovf(0, 40, n);
    wait_ovf(0, 40, n);
    chk(16'(n), 16'h0008);
    chk({15'h0, ctr_irq[0]}, 16'h0001);
    ld16(0, 16'hfffc);
    ctr_irq_en <= 3'h0;
    wait_ovf(0, 40, n);
    wait_ovf(0, 40, n);
    chk(16'(n), 16'h0010);
    chk({15'h0, ctr_irq[0]}, 16'h0000);
    wr(4'h2, 8'h00);
  endtask
  // full range on the every-clock counter
  task automatic t_range;
    int n;
    // load zero while stopped, then start: first wrap after 65536 clocks
    ld16(2, 16'h0000);
    wr(4'ha, 8'h90);
    wait_ovf(2, 70000, n);
    chk({15'h0, n == 65536}, 16'h0001);
    wr(4'ha, 8'h00);
  endtask
  task automatic t_event;
    logic [7:0] mode [3] = '{8'h50, 8'h58, 8'h10};
    logic [15:0] want [3] = '{16'h0004, 16'h0003, 16'h0000};
    logic [15:0] v;
    for (int k = 0; k < 3; k++) begin
      u_pin1.hold(1'b0, 4);
      ld16(1, 16'h0000);
      wr(4'h6, mode[k]);
      repeat (3) begin
        u_pin1.hold(1'b1, 3);
        u_pin1.hold(1'b0, 3);
      end
      u_pin1.hold(1'b1, 6);
      wr(4'h6, 8'h00);
      rd16(1, v);
      chk(v, want[k]);
    end
  endtask
  task automatic t_power;
    int n;
    u_pin0.hold(1'b0, 4);
    power_down <= 1'b1;
    ld16(0, 16'hffff);
    wr(4'h2, 8'h50);
    u_pin0.hold(1'b1, 0);
    wait_ovf(0, 12, n);
    chk({15'h0, wake_req}, 16'h0001);
    wr(4'h2, 8'h00);
    power_down <= 1'b0;
  endtask
  // pin low for 40 clocks is ten div4 ticks, give or take one
  task automatic t_pulse;
    logic [7:0] b;
    logic [15:0] v;
    u_pin0.hold(1'b1, 4);
    ld16(0, 16'h0000);
    wr(4'h2, 8'hd0);
    u_pin0.hold(1'b1, 8);
    u_pin0.hold(1'b0, 40);
    u_pin0.hold(1'b1, 8);
    rd(4'h2, b);
    chk({8'h00, b}, 16'h00c0);
    rd16(0, v);
    chk({15'h0, v >= 16'h0009 && v <= 16'h000b}, 16'h0001);
  endtask

  // watchdog, well past the longest count
  initial begin
    repeat (90000) @(posedge clk_sys);
    err_count++;
    finish_test();
  end
  initial begin
    rst = 1'b1;
    cpu_wr = 1'b0;
    cpu_rd = 1'b0;
    cpu_addr = 4'h0;
    cpu_wdata = 8'h00;
    power_down = 1'b0;
    ctr_irq_en = 3'h0;
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    t_regs();
    t_bytes();
    t_timer0();
    t_event();
    t_power();
    t_pulse();
    t_range();
    finish_test();
  end
endmodule // tmr_event_counters_test

bind tmr_event_counters tmr_event_counters_monitor u_mon (
  .clk_sys(clk_sys), .rst(rst), .cpu_addr(cpu_addr), .cpu_rd(cpu_rd),
  .cpu_rdata(cpu_rdata), .ctr_irq_en(ctr_irq_en),
  .power_down(power_down), .ctr_ovf_req(ctr_ovf_req),
  .ctr_irq(ctr_irq), .wake_req(wake_req));
`default_nettype wire
